// file: verilog/eq_defines.svh
`ifndef EQ_DEFINES_SVH
`define EQ_DEFINES_SVH

// ----------------------------------------------------------------
// queue geometry and codes
// ----------------------------------------------------------------
`define EQ_DEPTH        20
`define EQ_PTR_W        5
`define EQ_CNT_W        5
`define EQ_CODE_W       16
`define EQ_OVERFLOW     16'hfea2
`define EQ_NO_ERROR     16'h0000

`endif

// file: verilog/eq_pkg.sv
package eq_pkg;
  `include "eq_defines.svh"

  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef logic [`EQ_CODE_W-1:0] eq_code_type;
  typedef logic [`EQ_PTR_W-1:0]  eq_ptr_type;
  typedef logic [`EQ_CNT_W:0]    eq_cnt_type;

  typedef enum logic [0:0] {
    EQ_IDLE = 1'b0,
    EQ_FULL = 1'b1
  } eq_state_type;
endpackage

// file: verilog/eq_mem_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// storage port bundle between queue control and the entry memory
// ----------------------------------------------------------------
interface eq_mem_if;
  import eq_pkg::*;
  logic        wr_en;
  eq_ptr_type  wr_addr;
  eq_code_type wr_data;
  eq_ptr_type  rd_addr;
  eq_code_type rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface

// file: verilog/eq_mem.sv
`timescale 1ns/1ns
`include "eq_defines.svh"
// ----------------------------------------------------------------
// entry storage, registered read
// ----------------------------------------------------------------
module eq_mem
  import eq_pkg::*;
(
  input  wire logic sys_clk_i,
  eq_mem_if.mem     port
);
  eq_code_type store [0:`EQ_DEPTH-1];

  // read first (same-slot write returns old data), read data registered; no reset needed on storage
  always_ff @(posedge sys_clk_i) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end
endmodule

// file: verilog/eq_queue.sv
`timescale 1ns/1ns
`include "eq_defines.svh"
module eq_queue
  import eq_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        syn_err_i,
  input  wire eq_code_type syn_code_i,
  input  wire logic        hw_err_i,
  input  wire eq_code_type hw_code_i,
  input  wire logic        rd_req_i,
  input  wire logic        clear_i,
  output logic             rd_valid_o,
  output eq_code_type      rd_code_o,
  output logic             rd_empty_o,
  output logic             err_ind_o,
  output eq_cnt_type       count_o
);
  eq_mem_if mif();

  eq_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .port      (mif.mem)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eq_ptr_type   head;
  eq_ptr_type   tail;
  eq_cnt_type   count;
  eq_state_type state;
  logic         rd_pend;
  logic         rd_empty_pend;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // syntax source wins the port when both report; the hardware code is
  // then taken the next cycle only if the source holds it, a limitation
  wire         any_err  = syn_err_i | hw_err_i;
  eq_code_type in_code;
  assign in_code = syn_err_i ? syn_code_i : hw_code_i;
  wire         is_empty = (count == '0);
  wire         is_full  = (state == EQ_FULL);
  wire         do_rd    = rd_req_i & ~clear_i;
  wire         pop      = do_rd & ~is_empty;
  // full and reading: the pop frees a slot so the code is stored normally
  wire         push     = any_err & ~clear_i & (~is_full | pop);
  wire         ovf      = any_err & ~clear_i & is_full & ~pop;

  eq_ptr_type  head_inc;
  eq_ptr_type  tail_inc;
  eq_ptr_type  tail_last;
  assign head_inc  = (head == eq_ptr_type'(`EQ_DEPTH-1)) ? '0 : head + 1'b1;
  assign tail_inc  = (tail == eq_ptr_type'(`EQ_DEPTH-1)) ? '0 : tail + 1'b1;
  assign tail_last = (tail == '0) ? eq_ptr_type'(`EQ_DEPTH-1) : tail - 1'b1;

  eq_cnt_type next_count;
  assign next_count = clear_i ? '0 : count + eq_cnt_type'(push) - eq_cnt_type'(pop);

  // memory port: overflow rewrites the newest slot in place
  assign mif.wr_en   = push | ovf;
  assign mif.wr_addr = ovf ? tail_last : tail;
  assign mif.wr_data = ovf ? `EQ_OVERFLOW : in_code;
  assign mif.rd_addr = head;

  // ----------------------------------------------------------------
  // pointers and occupancy
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
      state <= EQ_IDLE;
    end else if (clear_i) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
      state <= EQ_IDLE;
    end else begin
      if (pop) head <= head_inc;
      if (push) tail <= tail_inc;
      count <= next_count;
      case (next_count == eq_cnt_type'(`EQ_DEPTH))
        1'b1:    state <= EQ_FULL;
        1'b0:    state <= EQ_IDLE;
        default: state <= EQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read answer: memory data lands one cycle after the pop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_pend       <= 1'b0;
      rd_empty_pend <= 1'b0;
    end else begin
      rd_pend       <= do_rd;
      rd_empty_pend <= do_rd & is_empty;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_valid_o <= 1'b0;
      rd_empty_o <= 1'b0;
      rd_code_o  <= '0;
      err_ind_o  <= 1'b0;
      count_o    <= '0;
    end else begin
      rd_valid_o <= rd_pend;
      rd_empty_o <= rd_empty_pend;
      rd_code_o  <= rd_empty_pend ? `EQ_NO_ERROR : mif.rd_data;
      err_ind_o  <= ~clear_i & (next_count != '0);
      count_o    <= clear_i ? '0 : next_count;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cap;
    @(posedge sys_clk_i) disable iff (reset_i)
      count <= eq_cnt_type'(`EQ_DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("queue over capacity");

  property p_ind;
    @(posedge sys_clk_i) disable iff (reset_i)
      ##1 (err_ind_o == (count != '0));
  endproperty
  a_ind: assert property (p_ind) else $error("indicator mismatch");

  property p_ind_off;
    @(posedge sys_clk_i) disable iff (reset_i)
      (pop && count == eq_cnt_type'(1) && !any_err) |=> !err_ind_o;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator stuck");

  sequence s_empty_rd;
    do_rd && is_empty;
  endsequence
  property p_noerr;
    @(posedge sys_clk_i) disable iff (reset_i)
      s_empty_rd |-> ##2 (rd_valid_o && rd_empty_o && rd_code_o == `EQ_NO_ERROR);
  endproperty
  a_noerr: assert property (p_noerr) else $error("empty read wrong");

  property p_pop;
    @(posedge sys_clk_i) disable iff (reset_i)
      (pop && !clear_i) |=> head == $past(head_inc);
  endproperty
  a_pop: assert property (p_pop) else $error("head not advanced");

  property p_ovf;
    @(posedge sys_clk_i) disable iff (reset_i)
      ovf |-> (mif.wr_en && mif.wr_addr == tail_last
               && mif.wr_data == `EQ_OVERFLOW) ##1 count == eq_cnt_type'(`EQ_DEPTH);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not marked");

  property p_clr;
    @(posedge sys_clk_i) disable iff (reset_i)
      clear_i |=> (count == '0 && !err_ind_o);
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  property p_both;
    @(posedge sys_clk_i) disable iff (reset_i)
      (pop && any_err && !clear_i) |=> count == $past(count);
  endproperty
  a_both: assert property (p_both) else $error("read plus error lost");

  property p_src;
    @(posedge sys_clk_i) disable iff (reset_i)
      (hw_err_i && !syn_err_i && push) |-> mif.wr_data == hw_code_i;
  endproperty
  a_src: assert property (p_src) else $error("hardware code lost");

  // answer timing is fixed so a requester can count cycles instead of polling
  sequence s_rd_taken;
    do_rd;
  endsequence
  property p_rd_lat;
    @(posedge sys_clk_i) disable iff (reset_i)
      s_rd_taken |-> ##2 rd_valid_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

  property p_clr_rd;
    @(posedge sys_clk_i) disable iff (reset_i)
      (rd_req_i && clear_i) |-> ##2 !rd_valid_o;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("read answered through clear");

  property p_push_cnt;
    @(posedge sys_clk_i) disable iff (reset_i)
      (push && !pop) |=> count == $past(count) + eq_cnt_type'(1);
  endproperty
  a_push_cnt: assert property (p_push_cnt) else $error("accepted code not held");

  property p_ind_on;
    @(posedge sys_clk_i) disable iff (reset_i)
      (any_err && !clear_i) |=> err_ind_o;
  endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator missed a report");

  // an overflow must not move either pointer, or older codes would be lost
  property p_ovf_keep;
    @(posedge sys_clk_i) disable iff (reset_i)
      ovf |=> (head == $past(head) && tail == $past(tail));
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow moved pointers");
endmodule

// file: testbench/eq_partner.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// error sources and readout requester
// ------------------------------------------------------------
module eq_partner
  import eq_pkg::*;
(
  input  wire logic   sys_clk_i,
  output eq_code_type syn_code_o,
  output eq_code_type hw_code_o,
  output logic        syn_err_o,
  output logic        hw_err_o,
  output logic        rd_req_o,
  output logic        clear_o
);
  // idle codes flip every cycle so a stale code never looks like a report
  initial begin
    {syn_err_o, hw_err_o, rd_req_o, clear_o} = 4'h0;
    syn_code_o = 16'h5a5a;
    hw_code_o  = 16'ha5a5;
  end

  // one cycle of requests; entered just after a rising edge, leaves likewise
  task automatic step(input logic rd, input logic ev, input logic hw,
                      input logic clr, input eq_code_type code);
    syn_err_o  = ev & ~hw;
    hw_err_o   = ev & hw;
    rd_req_o   = rd;
    clear_o    = clr;
    syn_code_o = (ev & ~hw) ? code : ~syn_code_o;
    hw_code_o  = (ev & hw) ? code : ~hw_code_o;
    @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import eq_pkg::*;
;
  logic        sys_clk_i;
  logic        reset_i;
  logic        syn_err, hw_err, rd_req, clear;
  eq_code_type syn_code, hw_code, rd_code_o;
  logic        rd_valid_o, rd_empty_o, err_ind_o;
  eq_cnt_type  count_o;
  int          num_errors = 0;
  int          compares = 0;

  eq_partner p (.sys_clk_i(sys_clk_i), .syn_code_o(syn_code), .hw_code_o(hw_code),
    .syn_err_o(syn_err), .hw_err_o(hw_err), .rd_req_o(rd_req), .clear_o(clear));
  eq_queue uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .syn_err_i(syn_err),
    .syn_code_i(syn_code), .hw_err_i(hw_err), .hw_code_i(hw_code), .rd_req_i(rd_req),
    .clear_i(clear), .rd_valid_o(rd_valid_o), .rd_code_o(rd_code_o),
    .rd_empty_o(rd_empty_o), .err_ind_o(err_ind_o), .count_o(count_o));

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // read, optionally with a report in the same cycle; bounded wait for the answer
  task automatic rd(input eq_code_type exp, input logic exp_e, input logic ev,
                    input eq_code_type code);
    int n = 0;
    p.step(1'b1, ev, 1'b0, 1'b0, code);
    while (rd_valid_o !== 1'b1 && n < 4) begin
      p.step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
      n++;
    end
    `CHK(rd_valid_o, 1'b1)
    `CHK(rd_empty_o, exp_e)
    `CHK(rd_code_o, exp)
    // a missing answer was counted above; stop here rather than run on skewed
    if (rd_valid_o !== 1'b1) summarize();
  endtask

  task automatic t_empty();
    rd(16'h0000, 1'b1, 1'b0, 16'h0000);
    `CHK(err_ind_o, 1'b0)
    $display("test empty done");
  endtask

  task automatic t_full();
    for (int i = 1; i <= 21; i++) p.step(1'b0, 1'b1, i[0], 1'b0, eq_code_type'(i));
    p.step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    `CHK(count_o, 6'h14)
    `CHK(err_ind_o, 1'b1)
    // read plus report while full: oldest leaves, new code joins, no overflow
    rd(16'h0001, 1'b0, 1'b1, 16'h0015);
    `CHK(count_o, 6'h14)
    for (int i = 2; i <= 20; i++) begin
      rd(i == 20 ? 16'hfea2 : eq_code_type'(i), 1'b0, 1'b0, 16'h0);
    end
    rd(16'h0015, 1'b0, 1'b0, 16'h0000);
    p.step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    `CHK(err_ind_o, 1'b0)
    $display("test full done");
  endtask

  task automatic t_simul();
    p.step(1'b0, 1'b1, 1'b1, 1'b0, 16'h0a0a);
    rd(16'h0a0a, 1'b0, 1'b1, 16'h0b0b);
    `CHK(count_o, 6'h01)
    rd(16'h0b0b, 1'b0, 1'b0, 16'h0000);
    $display("test simultaneous done");
  endtask

  task automatic t_clear();
    p.step(1'b0, 1'b1, 1'b0, 1'b0, 16'h0c0c);
    p.step(1'b0, 1'b1, 1'b1, 1'b0, 16'h0d0d);
    // clear wins over a read and a report in the same cycle
    p.step(1'b1, 1'b1, 1'b0, 1'b1, 16'h0e0e);
    p.step(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
    `CHK(rd_valid_o, 1'b0)
    `CHK(count_o, 6'h00)
    `CHK(err_ind_o, 1'b0)
    rd(16'h0000, 1'b1, 1'b0, 16'h0000);
    $display("test clear done");
  endtask

  // free-running 50 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // main sequence
  initial begin
    reset_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    `CHK(count_o, 6'h00)
    t_empty();
    t_full();
    t_simul();
    t_clear();
    summarize();
  end
endmodule
